// ### hw/asram_host.sv
/*
 * Host controller for an asynchronous static memory with common data lines.
 * Takes one read or write request at a time, sequences the pins with counted
 * minimum times, and can park the memory deselected for data retention.
 * Assumes the memory pins are resolved outside from the data output enable.
 */
`timescale 1ns/1ps
module asram_host
    import asram_pkg::*;
(
    // Clock and reset
    input  wire logic                i_clk,
    input  wire logic                i_rst,
    // Configuration
    input  wire logic                i_halfword,     // 1 halfword organisation
    input  wire logic                i_oe_in_write,  // Hold output enable low during the write pulse
    // Request
    input  wire logic                i_req_valid,
    input  wire asram_req_s          i_req,
    output logic                     o_req_ready,
    // Answer
    output logic                     o_rsp_valid,
    output logic [ASRAM_DW-1:0]      o_rsp_rdata,
    // Retention
    input  wire logic                i_retain_req,   // Ask to enter retention
    output logic                     o_retain_ok,    // Supply may be lowered
    // Memory pins
    output asram_pins_s              o_pins,
    input  wire logic [ASRAM_DW-1:0] i_dq,
    output logic [ASRAM_DW-1:0]      o_dq,
    output logic                     o_dq_oe_n       // Low while host drives data
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_PULSE, ST_RECOV, ST_READ, ST_TURN, ST_RETAIN
    } asram_state_e;

    asram_state_e        st_q, st_d;               // Sequencer state
    asram_pins_s         pins_q, pins_d;           // Registered pins
    logic [ASRAM_DW-1:0] dq_q, dq_d;               // Write data
    logic                dq_oe_n_q, dq_oe_n_d;     // Data drive, active low
    logic [ASRAM_DW-1:0] rdata_q, rdata_d;         // Read result
    logic                rsp_q, rsp_d;             // Answer pulse
    logic                tload;                    // Timer load
    logic [CW-1:0]       tcount;                   // Timer value
    logic                tdone;                    // Timer elapsed
    logic [ASRAM_DW-1:0] dq_s1_q, dq_s2_q;         // Data synchroniser
    logic [1:0]          lanes_n;                  // Lane enables to drive
    localparam logic [CW-1:0] RD_SYNC_CYC = CW'(2); // Read data synchroniser depth

    // ************************************************************
    // Phase timer
    // ************************************************************
    asram_timer u_timer (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_load  (tload),
        .i_count (tcount),
        .o_done  (tdone)
    );

    // Lanes only in halfword mode, otherwise both held active [R16]
    assign lanes_n = i_halfword ? ~i_req.lanes : 2'b00;

    // ************************************************************
    // Sequencer next state
    // ************************************************************
    always_comb begin
        st_d      = st_q;
        pins_d    = pins_q;
        dq_d      = dq_q;
        dq_oe_n_d = dq_oe_n_q;
        rdata_d   = rdata_q;
        rsp_d     = 1'b0;
        tload     = 1'b0;
        tcount    = ASRAM_AS_CYC;
        case (st_q)
            ST_IDLE: begin
                if (i_retain_req) begin
                    // Deselect before supply drops [R18]
                    pins_d.chip_select_n = 1'b1;
                    tload                = 1'b1;
                    tcount               = ASRAM_DR_CYC;
                    st_d                 = ST_RETAIN;
                end else if (i_req_valid && i_req.wr) begin
                    // Address, select, lanes and data first; write enable later [R6]
                    pins_d.addr                = i_req.addr;
                    pins_d.chip_select_n       = 1'b0;
                    pins_d.output_enable_n     = 1'b1;   // Lowered with the strobe [R12]
                    pins_d.upper_lane_enable_n = lanes_n[1];
                    pins_d.lower_lane_enable_n = lanes_n[0];
                    dq_d                       = i_req.wdata;
                    // Masked lane simply carries don't-care data [R1]
                    dq_oe_n_d                  = 1'b0;
                    tload                      = 1'b1;
                    tcount                     = ASRAM_AS_CYC;
                    st_d                       = ST_SETUP;
                end else if (i_req_valid) begin
                    // Read: write enable stays high throughout [R11]
                    pins_d.addr                = i_req.addr;
                    pins_d.chip_select_n       = 1'b0;
                    pins_d.output_enable_n     = 1'b0;
                    pins_d.write_enable_n      = 1'b1;
                    pins_d.upper_lane_enable_n = lanes_n[1];
                    pins_d.lower_lane_enable_n = lanes_n[0];
                    dq_oe_n_d                  = 1'b1;       // [R12]
                    tload                      = 1'b1;
                    // Access time plus synchroniser stages before the sample
                    tcount                     = ASRAM_RD_CYC + RD_SYNC_CYC;
                    st_d                       = ST_READ;
                end
            end
            ST_SETUP: begin
                if (tdone) begin
                    // Write starts at the later falling edge: write enable [R3] [R2]
                    pins_d.write_enable_n = 1'b0;
                    tload                 = 1'b1;
                    // Output enable falls with the strobe, so the memory never drives
                    // against host data; pulse then from the 8 ns figure, 2 cycles as with output enable high [R17] [R20] [R12]
                    pins_d.output_enable_n = !i_oe_in_write;
                    tcount = i_oe_in_write ? ASRAM_WP1_CYC : ASRAM_WP_CYC;
                    st_d   = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (tdone) begin
                    // Write ends on write enable rising; select and address held
                    // through the pulse cover select and address-to-end times [R4] [R5] [R7]
                    pins_d.write_enable_n = 1'b1;
                    // Output enable rises with the strobe: no read mode while data driven [R12]
                    pins_d.output_enable_n = 1'b1;
                    tload                 = 1'b1;
                    tcount                = ASRAM_WR_CYC;
                    st_d                  = ST_RECOV;
                end
            end
            ST_RECOV: begin
                if (tdone) begin
                    // Address held past end of write [R8]
                    pins_d.chip_select_n       = 1'b1;
                    pins_d.output_enable_n     = 1'b1;
                    pins_d.upper_lane_enable_n = 1'b1;
                    pins_d.lower_lane_enable_n = 1'b1;
                    dq_oe_n_d                  = 1'b1;
                    rsp_d                      = 1'b1;
                    st_d                       = ST_IDLE;
                end
            end
            ST_READ: begin
                if (tdone) begin
                    // Sample synchronised data, then release output enable
                    rdata_d                = dq_s2_q;
                    rsp_d                  = 1'b1;
                    pins_d.chip_select_n   = 1'b1;
                    pins_d.output_enable_n = 1'b1;
                    tload                  = 1'b1;
                    tcount                 = ASRAM_TA_CYC;
                    st_d                   = ST_TURN;
                end
            end
            ST_TURN: begin
                // Let memory drivers turn off before host may drive [R12]
                if (tdone) begin
                    pins_d.upper_lane_enable_n = 1'b1;
                    pins_d.lower_lane_enable_n = 1'b1;
                    st_d                       = ST_IDLE;
                end
            end
            ST_RETAIN: begin
                // Stay deselected while retention is asked
                if (!i_retain_req) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q      <= ST_IDLE;
            pins_q    <= '{chip_select_n: 1'b1, write_enable_n: 1'b1,
                           output_enable_n: 1'b1, upper_lane_enable_n: 1'b1,
                           lower_lane_enable_n: 1'b1, addr: '0};
            dq_q      <= '0;
            dq_oe_n_q <= 1'b1;
            rdata_q   <= '0;
            rsp_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            pins_q    <= pins_d;
            dq_q      <= dq_d;
            dq_oe_n_q <= dq_oe_n_d;
            rdata_q   <= rdata_d;
            rsp_q     <= rsp_d;
        end
    end

    // Two-stage synchroniser on the data pins
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
        end else begin
            dq_s1_q <= i_dq;
            dq_s2_q <= dq_s1_q;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_pins      = pins_q;
    assign o_dq        = dq_q;
    assign o_dq_oe_n   = dq_oe_n_q;
    assign o_rsp_valid = rsp_q;
    assign o_rsp_rdata = rdata_q;
    assign o_req_ready = (st_q == ST_IDLE) && !i_retain_req;
    assign o_retain_ok = (st_q == ST_RETAIN) && tdone;

endmodule // asram_host

// ### shared/asram_pkg.sv
/*
 * Package for the asynchronous static memory host controller: pin bundle,
 * request bundle, timing figures of the fastest grade and derived cycle counts.
 * Assumes a 200 MHz system clock and a halfword memory with common data lines.
 */
// Summary of operation
// (R1) Lower lane off writes upper byte only
// (R2) Write needs select, write and lane enables
// (R3) Write starts at later falling select/write edge
// (R4) Write ends at first rising select/write edge
// (R5) Select low at least 6 ns to end
// (R6) Address valid 1.5 ns before write start
// (R7) Address valid 6 ns before write end
// (R8) Address held 1.5 ns after write end
// (R9) Select falling with write keeps outputs off
// (R10) Read after write shows new address data
// (R11) Write enable stays high during reads
// (R12) Host never drives data during read mode
// (R13) Memory holds read data 3 ns after address
// (R14) Memory releases data 4 ns after write
// (R15) Memory turn-off beats turn-on, no overlap
// (R16) Lane enables used only in halfword mode
// (R17) Output enable low needs 8 ns write pulse
// (R18) Select high before retention, 0 ns set-up
// (R19) Memory powers down 8 ns after deselect
// (R20) Timing minimums counted in cycles, rounded up
package asram_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int ASRAM_AW = 21;                   // Address width, covers both organisations
    localparam int ASRAM_DW = 16;                   // Data width, halfword organisation
    localparam int ASRAM_BW = 8;                    // Byte width

    // ************************************************************
    // Timing figures in picoseconds, fastest grade
    // ************************************************************
    localparam int ASRAM_CLK_PS            = 5000;  // 200 MHz clock period
    localparam int ASRAM_ADDR_SETUP_PS     = 1500;  // addr_setup_to_write
    localparam int ASRAM_WRITE_PULSE_PS    = 6000;  // Pulse with output enable high
    localparam int ASRAM_WRITE_PULSE_OE_PS = 8000;  // write_pulse_oe_low
    localparam int ASRAM_WRITE_RECOV_PS    = 1500;  // write_recovery
    localparam int ASRAM_READ_CYCLE_PS     = 8000;  // Read cycle and access time
    localparam int ASRAM_OUT_OFF_PS        = 4000;  // write_to_output_off, turn-around
    localparam int ASRAM_RETAIN_SETUP_PS   = 0;     // Retention set-up

    // Round a least time up to whole cycles, never under one
    function automatic int asram_cyc(input int ps);
        int c;
        c = (ps + ASRAM_CLK_PS - 1) / ASRAM_CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int CW = 4;                          // Counter width
    localparam logic [CW-1:0] ASRAM_AS_CYC  = CW'(asram_cyc(ASRAM_ADDR_SETUP_PS));
    localparam logic [CW-1:0] ASRAM_WP_CYC  = CW'(asram_cyc(ASRAM_WRITE_PULSE_PS));
    localparam logic [CW-1:0] ASRAM_WP1_CYC = CW'(asram_cyc(ASRAM_WRITE_PULSE_OE_PS));
    localparam logic [CW-1:0] ASRAM_WR_CYC  = CW'(asram_cyc(ASRAM_WRITE_RECOV_PS));
    localparam logic [CW-1:0] ASRAM_RD_CYC  = CW'(asram_cyc(ASRAM_READ_CYCLE_PS));
    localparam logic [CW-1:0] ASRAM_TA_CYC  = CW'(asram_cyc(ASRAM_OUT_OFF_PS));
    localparam logic [CW-1:0] ASRAM_DR_CYC  = CW'(asram_cyc(ASRAM_RETAIN_SETUP_PS));

    // ************************************************************
    // Bundles
    // ************************************************************
    typedef struct packed {
        logic                wr;                    // 1 write, 0 read
        logic [ASRAM_AW-1:0] addr;                  // Word or byte address
        logic [ASRAM_DW-1:0] wdata;                 // Write data
        logic [1:0]          lanes;                 // Lane select, active high, [1] upper
    } asram_req_s;

    typedef struct packed {
        logic                chip_select_n;
        logic                write_enable_n;
        logic                output_enable_n;
        logic                upper_lane_enable_n;
        logic                lower_lane_enable_n;
        logic [ASRAM_AW-1:0] addr;
    } asram_pins_s;

endpackage : asram_pkg

// ### hw/asram_timer.sv
/*
 * Down-counter that times one phase of a memory access.
 * Assumes a load pulse from the sequencer on the same clock.
 */
`timescale 1ns/1ps
module asram_timer
    import asram_pkg::*;
(
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Control
    input  wire logic          i_load,
    input  wire logic [CW-1:0] i_count,
    // Status
    output logic               o_done
);

    logic [CW-1:0] cnt_q;                           // Remaining cycles
    logic [CW-1:0] cnt_d;                           // Next count

    // ************************************************************
    // Next count
    // ************************************************************
    always_comb begin
        if (i_load) begin
            cnt_d = i_count - CW'(1);              // Load cycle counts as the first
        end else if (cnt_q != '0) begin
            cnt_d = cnt_q - CW'(1);
        end else begin
            cnt_d = cnt_q;
        end
    end

    // Register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Phase elapsed; depends on the count only, so a load made on done is no loop
    assign o_done = (cnt_q == '0);

endmodule // asram_timer

// ### test/asram_mem_model.sv
/*
 * Behavioural halfword static memory for the host bench: 16 words, no clock.
 * Assumes the bench resolves the shared data wire from the host data enable only.
 */
`timescale 1ns/1ps
module asram_mem_model
    import asram_pkg::*;
(
    // Pins from the controller
    input  wire asram_pins_s         i_pins,
    input  wire logic [ASRAM_DW-1:0] i_dq,
    // Data drive back
    output logic [ASRAM_DW-1:0]      o_dq,
    output logic                     o_dq_en
);
    logic [ASRAM_DW-1:0] mem [16];  // Storage, low address bits only
    logic [ASRAM_DW-1:0] word;      // Word at the applied address
    logic                wr_act;    // Write overlap active
    logic                lo_on;     // Lower lane enabled
    logic                up_on;     // Upper lane enabled

    assign lo_on  = !i_pins.lower_lane_enable_n;
    assign up_on  = !i_pins.upper_lane_enable_n;
    assign wr_act = !i_pins.chip_select_n && !i_pins.write_enable_n;
    assign word   = mem[i_pins.addr[3:0]];
    // Drive only in read mode; select falling with write keeps it off
    assign o_dq_en = !i_pins.chip_select_n && !i_pins.output_enable_n
                     && i_pins.write_enable_n;
    // Disabled lanes show the inverse, never a stale copy
    assign o_dq = {(o_dq_en && up_on) ? word[15:8] : ~word[15:8],
                   (o_dq_en && lo_on) ? word[7:0] : ~word[7:0]};

    // Store each enabled lane during the overlap only
    always @(wr_act, i_dq, i_pins) begin
        if (wr_act && lo_on) begin
            mem[i_pins.addr[3:0]][7:0] = i_dq[7:0];
        end
        if (wr_act && up_on) begin
            mem[i_pins.addr[3:0]][15:8] = i_dq[15:8];
        end
    end
endmodule // asram_mem_model

// ### test/asram_asserts.sv
/*
 * Pin sequencing checks for the memory host controller.
 * Assumes one clock domain and the synchronous active-high reset.
 */
`timescale 1ns/1ps
module asram_asserts
    import asram_pkg::*;
(
    // Clock, reset, configuration
    input  wire logic        i_clk,
    input  wire logic        i_rst,
    input  wire logic        i_halfword,
    // Watched outputs
    input  wire logic        o_rsp_valid,
    input  wire logic        o_retain_ok,
    input  wire asram_pins_s o_pins,
    input  wire logic        o_dq_oe_n
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic cs;  // Select, active high view
    logic we;  // Write enable, active high view
    logic oe;  // Output enable, active high view
    assign cs = !o_pins.chip_select_n;
    assign we = !o_pins.write_enable_n;
    assign oe = !o_pins.output_enable_n;

    property p_we_in_sel; we |-> cs; endproperty
    a_we_in_sel: assert property (p_we_in_sel) else $error("write strobe without select");
    property p_setup; $rose(we) |-> cs && $past(cs) && $stable(o_pins.addr); endproperty
    a_setup: assert property (p_setup) else $error("address set-up short");
    property p_pulse; $rose(we) |-> we [*2]; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    property p_addr_hold; we |-> $stable(o_pins.addr); endproperty
    a_addr_hold: assert property (p_addr_hold) else $error("address moved in write");
    property p_recov; $fell(we) |=> $stable(o_pins.addr) && !cs; endproperty
    a_recov: assert property (p_recov) else $error("write recovery short");
    property p_end; $fell(we) && !$past(i_rst) |-> cs ##1 o_rsp_valid; endproperty
    a_end: assert property (p_end) else $error("write end not answered");
    property p_no_fight; cs && oe && !we |-> o_dq_oe_n; endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives in read mode");
    property p_rd_we; cs && o_dq_oe_n |-> !we; endproperty
    a_rd_we: assert property (p_rd_we) else $error("write strobe in read");
    property p_byte; cs && !i_halfword |-> !o_pins.upper_lane_enable_n
        && !o_pins.lower_lane_enable_n; endproperty
    a_byte: assert property (p_byte) else $error("lane pins used in byte mode");
    property p_retain; o_retain_ok |-> !cs && !$past(cs); endproperty
    a_retain: assert property (p_retain) else $error("retention while selected");

    c_write: cover property ($fell(we));
    c_read: cover property (cs && oe && o_dq_oe_n);
    c_retain: cover property (o_retain_ok);
endmodule // asram_asserts

bind asram_host asram_asserts asram_asserts_inst (.i_clk(i_clk), .i_rst(i_rst),
    .i_halfword(i_halfword), .o_rsp_valid(o_rsp_valid), .o_retain_ok(o_retain_ok),
    .o_pins(o_pins), .o_dq_oe_n(o_dq_oe_n));

// ### test/tb_top.sv
/*
 * Self-checking bench: controller against the behavioural memory.
 * Assumes inputs change on the falling edge of a 200 MHz clock.
 */
`timescale 1ns/1ps
module tb_top;
    import asram_pkg::*;
    logic clk = 0, rst = 1, hw = 1, oe_w = 0, vld = 0, ret = 0, rdy, rsp, rok, dq_oe_n, m_en;
    asram_req_s req = '0;
    asram_pins_s pins;
    logic [ASRAM_DW-1:0] rdata, h_dq, m_dq, dq_w;
    int err_count = 0, samples_checked = 0;

    assign dq_w = !dq_oe_n ? h_dq : m_dq;  // Resolved data wire
    asram_host asram_host_inst (.i_clk(clk), .i_rst(rst), .i_halfword(hw),
        .i_oe_in_write(oe_w), .i_req_valid(vld), .i_req(req), .o_req_ready(rdy),
        .o_rsp_valid(rsp), .o_rsp_rdata(rdata), .i_retain_req(ret), .o_retain_ok(rok),
        .o_pins(pins), .i_dq(dq_w), .o_dq(h_dq), .o_dq_oe_n(dq_oe_n));
    asram_mem_model asram_mem_model_inst (.i_pins(pins), .i_dq(dq_w), .o_dq(m_dq),
        .o_dq_en(m_en));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic test_done;
        $display("Checks %0d, errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // Compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // One request; returns cycles from take to answer
    task automatic do_req(input logic wr, input logic [20:0] a, input logic [15:0] d,
                          input logic [1:0] ln, output int lat);
        int n;
        req = '{wr: wr, addr: a, wdata: d, lanes: ln};
        vld = 1;
        n = 0;
        while (rdy !== 1'b1) begin
            @(negedge clk);
            if (++n > 40) begin err_count++; test_done(); end
        end
        @(negedge clk);
        vld = 0;
        lat = 0;
        while (rsp !== 1'b1) begin
            @(negedge clk);
            if (++lat > 40) begin err_count++; test_done(); end
        end
    endtask

    // Idle pins after reset
    task automatic t_idle;
        chk({pins.chip_select_n, pins.write_enable_n, pins.output_enable_n, dq_oe_n},
            16'h000f, "idle pins");
        chk(rdy, 1'b1, "ready");
    endtask

    // Full writes with both output-enable modes, then read back
    task automatic t_full;
        int l;
        int rd_cyc;
        rd_cyc = int'(ASRAM_RD_CYC) + 2;  // Access time plus two synchroniser stages
        for (int k = 0; k < 2; k++) begin
            oe_w = k[0];
            do_req(1'b1, 21'(k + 1), 16'ha5c3 ^ 16'(k), 2'b11, l);
            chk(16'(l), 16'(int'(ASRAM_AS_CYC) + int'(ASRAM_WR_CYC)
                + int'(k[0] ? ASRAM_WP1_CYC : ASRAM_WP_CYC)), "write time");
        end
        for (int k = 0; k < 2; k++) begin
            do_req(1'b0, 21'(k + 1), 16'h0000, 2'b11, l);
            chk(16'(l), 16'(rd_cyc), "read time");
            chk(rdata, 16'ha5c3 ^ 16'(k), "read back");
        end
        oe_w = 0;
    endtask

    // Single-lane writes keep the other byte
    task automatic t_lanes;
        int l;
        do_req(1'b1, 21'h4, 16'h1122, 2'b11, l);
        do_req(1'b1, 21'h4, 16'h3344, 2'b10, l);
        do_req(1'b0, 21'h4, 16'h0000, 2'b11, l);
        chk(rdata, 16'h3322, "upper only");
        do_req(1'b1, 21'h4, 16'h5566, 2'b01, l);
        do_req(1'b0, 21'h4, 16'h0000, 2'b11, l);
        chk(rdata, 16'h3366, "lower only");
    endtask

    // Byte organisation: lane pins low while selected, low byte returns
    task automatic t_byte;
        int l;
        hw = 0;
        do_req(1'b1, 21'h7, 16'h00b9, 2'b01, l);
        do_req(1'b0, 21'h7, 16'h0000, 2'b01, l);
        chk({8'h00, rdata[7:0]}, 16'h00b9, "byte read");
        hw = 1;
    endtask

    // Retention parks deselected and refuses requests
    task automatic t_retain;
        int n;
        ret = 1;
        n = 0;
        while (rok !== 1'b1) begin
            @(negedge clk);
            if (++n > 20) begin err_count++; test_done(); end
        end
        vld = 1;
        repeat (4) begin
            @(negedge clk);
            chk({pins.chip_select_n, rdy, rsp, m_en}, 16'h0008, "parked");
        end
        ret = 0;
        do_req(1'b0, 21'h1, 16'h0000, 2'b11, n);
        chk(rdata, 16'ha5c3, "after retention");
    endtask

    // Reset in mid-write releases select, write strobe and data drive
    task automatic t_mid_reset;
        req = '{wr: 1'b1, addr: 21'h9, wdata: 16'hffff, lanes: 2'b11};
        vld = 1;
        repeat (3) @(negedge clk);
        rst = 1;
        vld = 0;
        @(negedge clk);
        rst = 0;
        chk({pins.chip_select_n, pins.write_enable_n, dq_oe_n}, 16'h0007, "reset pins");
        @(negedge clk);
    endtask

    initial begin
        repeat (8) @(negedge clk);
        rst = 0;
        t_idle();
        t_full();
        t_lanes();
        t_byte();
        t_retain();
        t_mid_reset();
        t_idle();
        test_done();
    end
endmodule // tb_top
